// ==== sbsc_pkg.sv ====
package sbsc_pkg;

   // ************************************************************
   // widths and burst parameters
   // ************************************************************
   localparam int ADDR_W      = 16;
   localparam int DATA_W      = 32;
   localparam int BURST_W     = 2;
   localparam int FIFO_DEPTH  = 4;
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic [BURST_W-1:0] BURST_INIT = 2'h0;

   // ************************************************************
   // decoded operation, one-hot
   // ************************************************************
   typedef enum logic [6:0] {
      SBSC_OP_IDLE    = 7'h01,
      SBSC_OP_DESEL   = 7'h02,
      SBSC_OP_BEGIN_R = 7'h04,
      SBSC_OP_BEGIN_W = 7'h08,
      SBSC_OP_CONT_R  = 7'h10,
      SBSC_OP_CONT_W  = 7'h20,
      SBSC_OP_SUSP    = 7'h40
   } sbsc_op_type;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic primary_chip_select_n;
      logic secondary_chip_select_n;
      logic processor_addr_strobe_n;
      logic controller_addr_strobe_n;
      logic burst_advance_n;
      logic write_n;
   } sbsc_ctl_type;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
   } sbsc_acc_type;

endpackage

// ==== sbsc_fifo.sv ====
module sbsc_fifo
   import sbsc_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             resetn,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0]    wr_ff;
   logic [PW-1:0]    rd_ff;
   logic [PW:0]      cnt_ff;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;

   assign in_ready  = (cnt_ff != DEPTH[PW:0]);
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem_ff[rd_ff];

   always_ff @(posedge clock) begin
      if (push)
         mem_ff[wr_ff] <= in_data;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push)
            wr_ff <= (wr_ff == PW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
         if (pop)
            rd_ff <= (rd_ff == PW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
         cnt_ff <= cnt_ff + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      end
   end
endmodule

// ==== sbsc_top.sv ====
// Behaviour
// - deselect when primary high with controller strobe low, or primary low and secondary high with either strobe low
// - both selects low: processor strobe, or controller strobe with write high, begins read
// - both selects low, only controller strobe low, write low: begin burst write
// - no start, advance low, write high: step address, continue read
// - no start, advance low, write low: step address, continue write
// - no start, advance high, write high: hold address, suspend read
// - no start, advance high, write low: hold address, suspend write
// - single-bank variant ignores secondary select; primary alone qualifies, and primary high with either strobe low deselects
module sbsc_top
   import sbsc_pkg::*;
#(
   parameter bit SINGLE_BANK = 1'b0
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              resetn,
   // bus master strobes
   input  wire logic              primary_chip_select_n,
   input  wire logic              secondary_chip_select_n,
   input  wire logic              processor_addr_strobe_n,
   input  wire logic              controller_addr_strobe_n,
   input  wire logic              burst_advance_n,
   input  wire logic              write_n,
   input  wire logic [ADDR_W-1:0] ext_addr,
   // decoded cycle status
   output logic                   selected,
   output logic                   burst_write,
   output logic [ADDR_W-1:0]      burst_addr,
   output logic [6:0]             op_code,
   // access stream to the array
   output logic                   acc_valid,
   input  wire logic              acc_ready,
   output logic                   acc_write,
   output logic [ADDR_W-1:0]      acc_addr,
   // stall seen by the master when the stream backs up
   output logic                   stall
);

   // ************************************************************
   // decode
   // ************************************************************
   sbsc_ctl_type ctl;
   assign ctl = '{primary_chip_select_n, secondary_chip_select_n,
                  processor_addr_strobe_n, controller_addr_strobe_n,
                  burst_advance_n, write_n};

   function automatic sbsc_op_type decode(input sbsc_ctl_type c,
                                          input bit single);
      logic sec_hi;
      logic no_start;
      sec_hi   = single ? 1'b0 : c.secondary_chip_select_n;
      no_start = c.controller_addr_strobe_n &
                 (c.processor_addr_strobe_n | c.primary_chip_select_n);
      decode   = SBSC_OP_IDLE;
      if (c.primary_chip_select_n & !c.controller_addr_strobe_n)
         decode = SBSC_OP_DESEL;
      else if (c.primary_chip_select_n & !c.processor_addr_strobe_n &
               single)
         decode = SBSC_OP_DESEL;
      else if (!c.primary_chip_select_n & sec_hi &
               (!c.processor_addr_strobe_n |
                !c.controller_addr_strobe_n))
         decode = SBSC_OP_DESEL;
      else if (!c.primary_chip_select_n & !c.processor_addr_strobe_n)
         decode = SBSC_OP_BEGIN_R;
      else if (!c.primary_chip_select_n & !c.controller_addr_strobe_n)
         decode = c.write_n ? SBSC_OP_BEGIN_R
                            : SBSC_OP_BEGIN_W;
      else if (no_start & !c.burst_advance_n)
         decode = c.write_n ? SBSC_OP_CONT_R
                            : SBSC_OP_CONT_W;
      else if (no_start)
         decode = SBSC_OP_SUSP;
      return decode;
   endfunction

   sbsc_op_type op;
   assign op = decode(ctl, SINGLE_BANK);

   wire is_begin = (op == SBSC_OP_BEGIN_R) | (op == SBSC_OP_BEGIN_W);
   wire is_cont  = (op == SBSC_OP_CONT_R) | (op == SBSC_OP_CONT_W);
   wire is_susp  = (op == SBSC_OP_SUSP);
   wire is_desel = (op == SBSC_OP_DESEL);

   // ************************************************************
   // burst address state
   // ************************************************************
   logic [ADDR_W-1:0]  base_ff;
   logic [BURST_W-1:0] cnt_ff;
   logic               sel_ff;
   logic               wr_ff;
   logic [6:0]         op_ff;
   logic [ADDR_W-1:0]  addr_ff;
   logic               stall_ff;

   // interleaved (XOR) order inside the burst; count start and step are package choices
   wire [BURST_W-1:0] nxt_cnt = is_begin ? BURST_INIT
                              : is_cont  ? cnt_ff + BURST_STEP
                              : cnt_ff;
   wire [ADDR_W-1:0]  nxt_base = is_begin ? ext_addr : base_ff;
   wire [ADDR_W-1:0]  nxt_addr = {nxt_base[ADDR_W-1:BURST_W],
                                  nxt_base[BURST_W-1:0] ^ nxt_cnt};
   wire nxt_sel = is_begin ? 1'b1 : is_desel ? 1'b0 : sel_ff;
   wire nxt_wr  = is_begin ? (op == SBSC_OP_BEGIN_W)
                : is_cont  ? (op == SBSC_OP_CONT_W)
                : is_susp  ? !write_n
                : wr_ff;

   // an access enters the stream on begin or continue while selected
   wire access  = is_begin | (is_cont & sel_ff);
   sbsc_acc_type acc_in;
   sbsc_acc_type acc_out;
   logic         fifo_in_ready;
   assign acc_in = '{nxt_wr, nxt_addr};

   // a full stream holds the burst where it is, like a suspend
   wire take    = ~stall_ff;

   // own count of the buffer, so that stall is up before a push is lost
   logic [2:0] occ_ff;
   wire  [2:0] nxt_occ = occ_ff + {2'h0, access & take}
                       - {2'h0, acc_valid & acc_ready};

   always_ff @(posedge clock) begin
      if (!resetn) begin
         base_ff  <= '0;
         cnt_ff   <= BURST_INIT;
         sel_ff   <= 1'b0;
         wr_ff    <= 1'b0;
         op_ff    <= SBSC_OP_IDLE;
         addr_ff  <= '0;
         stall_ff <= 1'b0;
         occ_ff   <= '0;
      end else begin
         occ_ff   <= nxt_occ;
         stall_ff <= (nxt_occ == 3'(FIFO_DEPTH));
         if (take) begin
            op_ff   <= op;
            base_ff <= nxt_base;
            cnt_ff  <= nxt_cnt;
            sel_ff  <= nxt_sel;
            wr_ff   <= nxt_wr;
            addr_ff <= nxt_addr;
         end
      end
   end

   // ************************************************************
   // access stream
   // ************************************************************
   sbsc_fifo #(
      .WIDTH ($bits(sbsc_acc_type)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .resetn    (resetn),
      .in_valid  (access & take),
      .in_ready  (fifo_in_ready),
      .in_data   (acc_in),
      .out_valid (acc_valid),
      .out_ready (acc_ready),
      .out_data  (acc_out)
   );

   assign acc_write   = acc_out.write;
   assign acc_addr    = acc_out.addr;
   assign selected    = sel_ff;
   assign burst_write = wr_ff;
   assign burst_addr  = addr_ff;
   assign op_code     = op_ff;
   assign stall       = stall_ff;
endmodule

// ==== sbsc_top_properties.sv ====
module sbsc_chk
   import sbsc_pkg::*;
#(
   parameter bit SINGLE_BANK = 1'b0
) (
   // clock and reset
   input wire logic              clock,
   input wire logic              resetn,
   // strobes
   input wire logic              primary_chip_select_n,
   input wire logic              secondary_chip_select_n,
   input wire logic              processor_addr_strobe_n,
   input wire logic              controller_addr_strobe_n,
   input wire logic              burst_advance_n,
   input wire logic              write_n,
   input wire logic [ADDR_W-1:0] ext_addr,
   // status
   input wire logic              selected,
   input wire logic              burst_write,
   input wire logic [ADDR_W-1:0] burst_addr,
   input wire logic [6:0]        op_code,
   input wire logic              acc_valid,
   input wire logic              stall
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   wire p   = primary_chip_select_n;
   wire s   = secondary_chip_select_n & !SINGLE_BANK;
   wire ps  = processor_addr_strobe_n;
   wire cs  = controller_addr_strobe_n;
   wire tk  = !stall;
   wire ds  = (p && (!cs || (SINGLE_BANK && !ps))) || (!p && s && (!ps || !cs));
   wire bg  = !p && !s && (!ps || !cs);
   wire ns  = cs && (ps || p) && !ds;
   wire rd  = !ps || write_n;
   sequence s_hold; $stable(burst_addr) && $stable(selected); endsequence
   sequence s_step;
      burst_addr[ADDR_W-1:2] == $past(burst_addr[ADDR_W-1:2]) &&
      burst_addr[1:0] != $past(burst_addr[1:0]);
   endsequence
   chk_desel_cycle: assert property (tk && ds |=> op_code == 7'h02 && !selected)
      else $error("deselect not decoded");
   chk_begin_read: assert property (tk && bg && rd |=> op_code == 7'h04 && selected
      && !burst_write && burst_addr == $past(ext_addr))
      else $error("begin read not decoded");
   chk_begin_write: assert property (tk && bg && !rd |=> op_code == 7'h08
      && burst_write && burst_addr == $past(ext_addr))
      else $error("begin write not decoded");
   chk_cont_read: assert property (tk && ns && !burst_advance_n && write_n
      |=> op_code == 7'h10 ##0 s_step)
      else $error("continue read not decoded");
   chk_cont_write: assert property (tk && ns && !burst_advance_n && !write_n
      |=> op_code == 7'h20 ##0 s_step)
      else $error("continue write not decoded");
   chk_susp_read: assert property (tk && ns && burst_advance_n && write_n
      |=> op_code == 7'h40 ##0 s_hold)
      else $error("suspend read moved address");
   chk_susp_write: assert property (tk && ns && burst_advance_n && !write_n
      |=> op_code == 7'h40 ##0 s_hold)
      else $error("suspend write moved address");
   chk_stall_freeze: assert property (stall |=> s_hold ##0 $stable(op_code))
      else $error("state moved during stall");
   chk_reset_vals: assert property (@(posedge clock) disable iff (1'b0)
      !resetn |=> op_code == 7'h01 && !acc_valid && !selected)
      else $error("reset values wrong");
endmodule
bind sbsc_top sbsc_chk #(.SINGLE_BANK(SINGLE_BANK)) chk_u (.clock(clock),
   .resetn(resetn), .primary_chip_select_n(primary_chip_select_n),
   .secondary_chip_select_n(secondary_chip_select_n),
   .processor_addr_strobe_n(processor_addr_strobe_n),
   .controller_addr_strobe_n(controller_addr_strobe_n),
   .burst_advance_n(burst_advance_n), .write_n(write_n),
   .ext_addr(ext_addr), .selected(selected), .burst_write(burst_write),
   .burst_addr(burst_addr), .op_code(op_code), .acc_valid(acc_valid),
   .stall(stall));

// ==== sbsc_sink_model.sv ====
module sbsc_sink (
   // clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // access stream
   input  wire logic acc_valid,
   input  wire logic drain,
   output logic      acc_ready,
   output int        n_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   initial acc_ready = 1'b0;
   initial n_seen = 0;
   // a slow array side backs the four-word buffer up until it stalls
   always @(posedge clock) begin
      if (resetn && acc_valid && acc_ready) n_seen <= n_seen + 1;
      acc_ready <= drain || ($urandom_range(3) == 0);
   end
endmodule

// ==== sbsc_top_bench.sv ====
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("BAD %0t value mismatch", $time); end end
module sbsc_top_bench;
   import sbsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct { logic [6:0] op; logic sel; logic [15:0] ad; logic wr; }
      sbsc_note_type;
   logic [16:0] aq[$], ae;
   logic wx = 1'b0;
   logic clock = 1'b0, resetn = 1'b0, drain = 1'b0;
   sbsc_ctl_type c = 6'h3F;
   logic [15:0] a = 16'h0000, base = 16'h0000, ad;
   logic [6:0] op_code, op;
   logic [1:0] cnt = 2'h0;
   logic sel = 1'b0, selected, burst_write, acc_valid, acc_ready, stall, aw;
   logic [15:0] burst_addr, acc_addr;
   int n_mismatch = 0, n_tests = 0, n_acc = 0, n_seen;
   sbsc_note_type q[$], n;
   always #20 clock = ~clock;
   sbsc_top dut_u (.clock(clock), .resetn(resetn),
      .primary_chip_select_n(c.primary_chip_select_n),
      .secondary_chip_select_n(c.secondary_chip_select_n),
      .processor_addr_strobe_n(c.processor_addr_strobe_n),
      .controller_addr_strobe_n(c.controller_addr_strobe_n),
      .burst_advance_n(c.burst_advance_n), .write_n(c.write_n),
      .ext_addr(a), .selected(selected), .burst_write(burst_write),
      .burst_addr(burst_addr), .op_code(op_code), .acc_valid(acc_valid),
      .acc_ready(acc_ready), .acc_write(aw), .acc_addr(acc_addr),
      .stall(stall));
   sbsc_sink sink_u (.clock(clock), .resetn(resetn), .acc_valid(acc_valid),
      .drain(drain), .acc_ready(acc_ready), .n_seen(n_seen));
   function automatic logic [6:0] dec(sbsc_ctl_type k);
      logic p, s, ps, cs;
      {p, s, ps, cs} = k[5:2];
      if ((p && !cs) || (!p && s && (!ps || !cs))) return SBSC_OP_DESEL;
      if (!p && !s && (!ps || !cs))
         return (!ps || k.write_n) ? SBSC_OP_BEGIN_R : SBSC_OP_BEGIN_W;
      if (!k.burst_advance_n) return k.write_n ? SBSC_OP_CONT_R : SBSC_OP_CONT_W;
      return SBSC_OP_SUSP;
   endfunction
   // the inputs standing at an unstalled edge are taken there
   task automatic step(input sbsc_ctl_type nc, input logic [15:0] na);
      @(posedge clock);
      if (resetn === 1'b1 && stall === 1'b0) begin
         op = dec(c);
         if (op == SBSC_OP_DESEL) sel = 1'b0;
         if (op == SBSC_OP_BEGIN_R || op == SBSC_OP_BEGIN_W) begin
            sel = 1'b1;
            base = a;
            cnt = 2'h0;
            wx = (op == SBSC_OP_BEGIN_W);
            n_acc++;
            aq.push_back({wx, base});
         end
         if (op == SBSC_OP_CONT_R || op == SBSC_OP_CONT_W) begin
            cnt = cnt + 2'h1;
            wx = (op == SBSC_OP_CONT_W);
            if (sel) begin
               n_acc++;
               aq.push_back({wx, base[15:2], base[1:0] ^ cnt});
            end
         end
         if (op == SBSC_OP_SUSP) wx = !c.write_n;
         q.push_back('{op, sel, {base[15:2], base[1:0] ^ cnt}, wx});
      end
      c <= nc;
      a <= na;
   endtask
   always @(posedge clock) begin
      #1;
      while (q.size() > 0) begin
         n = q.pop_front();
         `CHK(op_code, n.op)
         `CHK(selected, n.sel)
         if (n.op != SBSC_OP_DESEL) `CHK(burst_addr, n.ad)
         `CHK(burst_write, n.wr)
      end
   end
   // a handshake stands from one rising edge to the next
   always @(negedge clock) begin
      if (resetn === 1'b1 && acc_valid === 1'b1 && acc_ready === 1'b1) begin
         ae = (aq.size() > 0) ? aq.pop_front() : 17'h1FFFF;
         `CHK({aw, acc_addr}, ae)
      end
   end
   task automatic complete_run();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(69292));
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      // suspend, two deselects, suspend, deselect, two suspends
      step(6'h0F, 16'hA5A3);
      step(6'h2B, 16'h0000);
      step(6'h2B, 16'h0000);
      step(6'h3F, 16'h0000);
      step(6'h32, 16'h1234);
      step(6'h3F, 16'h0000);
      step(6'h3F, 16'h0000);
      $display("directed walk done");
      // random strobes with a stalling consumer
      repeat (3000) step(6'($urandom), 16'($urandom));
      $display("random traffic done");
      drain <= 1'b1;
      repeat (30) step(6'h3F, 16'h0000);
      `CHK(n_seen, n_acc)
      `CHK(acc_valid, 1'b0)
      $display("drain done");
      complete_run();
   end
endmodule
